// file: timer2_pkg.sv
/*
 * constants, field layouts and carrier types for the second timer block.
 * assumes a 32-bit ahb-lite register bus; registers sit at index * 4.
 */
package timer2_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONTROL = 8'hc8;
   localparam logic [7:0] IDX_RELOAD_LOW = 8'hca;
   localparam logic [7:0] IDX_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] IDX_COUNT_LOW = 8'hcc;
   localparam logic [7:0] IDX_COUNT_HIGH = 8'hcd;
   localparam logic [7:0] IDX_EXTRA = 8'hce;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hd0;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hd1;

   // address field positions
   localparam int unsigned ADDR_IDX_LSB = 2;
   localparam int unsigned ADDR_IDX_MSB = 9;
   localparam int unsigned ADDR_TOP_LSB = 10;

   // extra control register bits
   localparam int unsigned EXTRA_UPDOWN = 0;
   localparam int unsigned EXTRA_DUAL = 1;

   // interrupt status and mask bits
   localparam int unsigned IRQ_OVF = 0;
   localparam int unsigned IRQ_EXT = 1;
   localparam int unsigned IRQ_W = 2;

   // reset values and counter maximum
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] EXTRA_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

   // ahb-lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic HRESP_OKAY = 1'b0;

   // control register, bit 7 first
   typedef struct packed {
      logic overflow_flag;
      logic external_event_flag;
      logic rx_baud_select;
      logic tx_baud_select;
      logic external_trigger_enable;
      logic run_control;
      logic counter_select;
      logic capture_reload_select;
   } control_type;

   // latched write address phase
   typedef struct packed {
      logic sel;
      logic [7:0] index;
   } wr_req_type;

   // baud clock pulses handed to the serial port
   typedef struct packed {
      logic rx_tick;
      logic tx_tick;
   } baud_type;

endpackage : timer2_pkg

// file: timer2_fall_detect.sv
/*
 * falling edge detector for a pin sampled every clock.
 * assumes the pin is already synchronous to the clock.
 */
`timescale 1ns/100ps
`default_nettype none
module timer2_fall_detect
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic fall
);
   logic prev_q;

   // reset high so a pin held low at start counts as one edge
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_q <= 1'b1;
      else
         prev_q <= pin;
   end

   assign fall = prev_q & ~pin;

   a_fall_single: assert property (@(posedge clk) disable iff (!rst_n)
      fall |=> !fall)
      else $error("fall pulse lasted two cycles");

endmodule : timer2_fall_detect
`default_nettype wire

// file: timer2_irq.sv
/*
 * sticky interrupt status with write-one-to-clear and a mask.
 * assumes events are one-cycle pulses; set wins over clear.
 */
`timescale 1ns/100ps
`default_nettype none
module timer2_irq
#(
   parameter int unsigned WIDTH = 2
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] event_in,
   input wire logic clear_we,
   input wire logic mask_we,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] status_q,
   output logic [WIDTH-1:0] mask_q,
   output logic irq_q
);
   logic [WIDTH-1:0] status_d;
   logic [WIDTH-1:0] mask_d;

   if (WIDTH < 1)
      $error("timer2_irq needs at least one event");

   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      assign status_d[i] = event_in[i] | (status_q[i] & ~(clear_we & wdata[i]));
   end

   assign mask_d = mask_we ? wdata : mask_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_q <= '0;
         mask_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         status_q <= status_d;
         mask_q <= mask_d;
         irq_q <= |(status_d & mask_d);
      end
   end

   a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
      irq_q == |(status_q & mask_q))
      else $error("interrupt level disagrees with status and mask");

   a_status_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      (status_q != '0 && !clear_we) |=> (status_q & $past(status_q)) == $past(status_q))
      else $error("status bit dropped without a clear");

endmodule : timer2_irq
`default_nettype wire

// file: timer2_core.sv
/*
 * second timer: 16-bit counter, capture/reload pair, control flags,
 * serial baud hand-off and sticky interrupts behind an ahb-lite slave.
 * assumes pins synchronous to hclk and a master that idles in data phases.
 */
// Functional notes
// - count visible as high and low byte
// - capture/reload value as two byte registers
// - control register resets to zero, fixed order
// - overflow sets flag; only software clears
// - no overflow flag with baud selects set
// - enabled trigger fall sets external flag
// - external flag requests interrupt; software clears
// - no external interrupt in updown/dual-slope
// - trigger pin acts only when enabled, nonserial
// - capture or reload per select; baud forces reload
// - count clocks or event pin falling edges
`timescale 1ns/100ps
`default_nettype none
module timer2_core
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic event_count_pin,
   input wire logic external_trigger_pin,
   output logic irq,
   output var timer2_pkg::baud_type baud_tick,
   output var timer2_pkg::baud_type baud_source
);
   import timer2_pkg::*;

   control_type ctl_q;
   control_type ctl_d;
   logic [7:0] extra_q;
   logic [7:0] extra_d;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic [15:0] count_hw;
   logic [15:0] reload_q;
   logic [15:0] reload_d;
   logic [15:0] reload_hw;
   wr_req_type wreq_q;
   logic [31:0] hrdata_q;
   baud_type tick_q;
   baud_type source_q;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic irq_line;

   // bus decode
   wire addr_phase = hsel & hready & htrans[1];
   wire [7:0] addr_idx = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
   wire addr_ok = (haddr[31:ADDR_TOP_LSB] == '0) & (haddr[1:0] == 2'b00);
   wire rd_take = addr_phase & ~hwrite;
   wire wr_take = addr_phase & hwrite & addr_ok;
   wire [7:0] wdata = hwdata[7:0];
   wire we_ctl = wreq_q.sel & (wreq_q.index == IDX_CONTROL);
   wire we_rl = wreq_q.sel & (wreq_q.index == IDX_RELOAD_LOW);
   wire we_rh = wreq_q.sel & (wreq_q.index == IDX_RELOAD_HIGH);
   wire we_cl = wreq_q.sel & (wreq_q.index == IDX_COUNT_LOW);
   wire we_ch = wreq_q.sel & (wreq_q.index == IDX_COUNT_HIGH);
   wire we_extra = wreq_q.sel & (wreq_q.index == IDX_EXTRA);
   wire we_clear = wreq_q.sel & (wreq_q.index == IDX_IRQ_STATUS);
   wire we_mask = wreq_q.sel & (wreq_q.index == IDX_IRQ_MASK);

   // register read selection
   logic [7:0] rd_byte;
   always_comb
   begin
      case (addr_idx)
         IDX_CONTROL: rd_byte = ctl_q;
         IDX_RELOAD_LOW: rd_byte = reload_q[7:0];
         IDX_RELOAD_HIGH: rd_byte = reload_q[15:8];
         IDX_COUNT_LOW: rd_byte = count_q[7:0];
         IDX_COUNT_HIGH: rd_byte = count_q[15:8];
         IDX_EXTRA: rd_byte = extra_q;
         IDX_IRQ_STATUS: rd_byte = {{(8-IRQ_W){1'b0}}, irq_status};
         IDX_IRQ_MASK: rd_byte = {{(8-IRQ_W){1'b0}}, irq_mask};
         default: rd_byte = 8'h00;
      endcase
   end
   wire [31:0] rd_word = (rd_take & addr_ok) ? {24'h000000, rd_byte} : RDATA_RESET;

   // pin edges
   logic count_fall;
   logic trig_fall;

   timer2_fall_detect u_count_edge
   (
      .clk(hclk),
      .rst_n(hresetn),
      .pin(event_count_pin),
      .fall(count_fall)
   );

   timer2_fall_detect u_trig_edge
   (
      .clk(hclk),
      .rst_n(hresetn),
      .pin(external_trigger_pin),
      .fall(trig_fall)
   );

   // counting
   wire serial = ctl_q.rx_baud_select | ctl_q.tx_baud_select;
   wire count_tick = ctl_q.run_control & (ctl_q.counter_select ? count_fall : 1'b1);
   wire at_max = (count_q == COUNT_MAX);
   wire ovf_event = count_tick & at_max;
   // trigger only when enabled and not a baud source
   wire trig = trig_fall & ctl_q.external_trigger_enable & ~serial;
   // baud use forces reload regardless of the select
   wire reload_mode = serial | ~ctl_q.capture_reload_select;
   wire capture_evt = trig & ctl_q.capture_reload_select;
   wire reload_evt = (ovf_event & reload_mode) | (trig & ~ctl_q.capture_reload_select);
   wire ovf_set = ovf_event & ~serial;
   wire ext_set = capture_evt | (trig & ~ctl_q.capture_reload_select);
   wire ext_irq_block = extra_q[EXTRA_UPDOWN] | extra_q[EXTRA_DUAL];
   wire [IRQ_W-1:0] irq_events = {ext_set & ~ext_irq_block, ovf_set};

   assign count_hw = reload_evt ? reload_q : (count_tick ? 16'(count_q + 16'h0001) : count_q);
   // software byte writes win over the counter in the same cycle
   assign count_d = {we_ch ? wdata : count_hw[15:8], we_cl ? wdata : count_hw[7:0]};
   assign reload_hw = capture_evt ? count_q : reload_q;
   assign reload_d = {we_rh ? wdata : reload_hw[15:8], we_rl ? wdata : reload_hw[7:0]};
   assign extra_d = we_extra ? wdata : extra_q;

   // hardware set wins over a software clear
   always_comb
   begin
      ctl_d = we_ctl ? control_type'(wdata) : ctl_q;
      ctl_d.overflow_flag = ctl_d.overflow_flag | ovf_set;
      ctl_d.external_event_flag = ctl_d.external_event_flag | ext_set;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctl_q <= control_type'(CONTROL_RESET);
         extra_q <= EXTRA_RESET;
         count_q <= COUNT_RESET;
         reload_q <= RELOAD_RESET;
      end
      else
      begin
         ctl_q <= ctl_d;
         extra_q <= extra_d;
         count_q <= count_d;
         reload_q <= reload_d;
      end
   end

   // bus side flops; zero wait states
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wreq_q <= '0;
         hrdata_q <= RDATA_RESET;
      end
      else
      begin
         wreq_q <= '{sel: wr_take, index: addr_idx};
         hrdata_q <= rd_word;
      end
   end

   // serial port hand-off
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tick_q <= '0;
         source_q <= '0;
      end
      else
      begin
         tick_q <= '{rx_tick: ovf_event & ctl_q.rx_baud_select,
                     tx_tick: ovf_event & ctl_q.tx_baud_select};
         source_q <= '{rx_tick: ctl_d.rx_baud_select, tx_tick: ctl_d.tx_baud_select};
      end
   end

   timer2_irq #(.WIDTH(IRQ_W)) u_irq
   (
      .clk(hclk),
      .rst_n(hresetn),
      .event_in(irq_events),
      .clear_we(we_clear),
      .mask_we(we_mask),
      .wdata(wdata[IRQ_W-1:0]),
      .status_q(irq_status),
      .mask_q(irq_mask),
      .irq_q(irq_line)
   );

   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_q;
   assign irq = irq_line;
   assign baud_tick = tick_q;
   assign baud_source = source_q;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_ovf_sets_flag: assert property (ovf_event && !serial |=> ctl_q.overflow_flag)
      else $error("overflow did not set the overflow flag");

   a_ovf_flag_sticky: assert property (ctl_q.overflow_flag && !we_ctl |=> ctl_q.overflow_flag)
      else $error("overflow flag cleared by hardware");

   a_ovf_serial_quiet: assert property (serial && !we_ctl |=> !$rose(ctl_q.overflow_flag))
      else $error("overflow flag set while clocking the serial port");

   a_ext_sets_flag: assert property (trig_fall && ctl_q.external_trigger_enable && !serial
      |=> ctl_q.external_event_flag)
      else $error("trigger edge did not set the external flag");

   a_ext_flag_sticky: assert property (ctl_q.external_event_flag && !we_ctl |=> ctl_q.external_event_flag)
      else $error("external flag cleared by hardware");

   a_trig_ignored: assert property ((!ctl_q.external_trigger_enable || serial) && !we_ctl
      |=> !$rose(ctl_q.external_event_flag))
      else $error("trigger pin acted while disabled");

   // software writes land, except flags that hardware sets that cycle
   a_ctl_write: assert property (we_ctl |=> ctl_q[5:0] == $past(wdata[5:0]))
      else $error("control write did not land");

   a_ovf_soft_write: assert property (we_ctl && !ovf_set |=> ctl_q.overflow_flag == $past(wdata[7]))
      else $error("overflow flag ignored a software write");

   a_ovf_irq_set: assert property (ovf_set |=> irq_status[IRQ_OVF])
      else $error("overflow did not set its interrupt status");

   a_ext_irq_set: assert property (ext_set && !ext_irq_block |=> irq_status[IRQ_EXT])
      else $error("external event did not set its interrupt status");

   // counting, capture and reload
   a_capture_value: assert property (capture_evt && !we_rl && !we_rh
      |=> reload_q == $past(count_q))
      else $error("capture did not copy the count");

   a_reload_value: assert property (ovf_event && reload_mode && !we_cl && !we_ch
      |=> count_q == $past(reload_q))
      else $error("overflow did not reload the count");

   a_trig_reload: assert property (trig && !ctl_q.capture_reload_select && !we_cl && !we_ch
      |=> count_q == $past(reload_q))
      else $error("trigger edge did not reload the count");

   a_serial_no_capture: assert property (serial |-> !capture_evt)
      else $error("capture while clocking the serial port");

   a_reload_holds: assert property (!capture_evt && !we_rl && !we_rh |=> $stable(reload_q))
      else $error("capture/reload value moved without cause");

   a_timer_counts: assert property (ctl_q.run_control && !ctl_q.counter_select && !at_max
      && !reload_evt && !we_cl && !we_ch |=> count_q == 16'($past(count_q) + 16'h0001))
      else $error("timer did not advance by one");

   a_counter_holds: assert property (ctl_q.counter_select && !count_fall && !reload_evt
      && !we_cl && !we_ch |=> $stable(count_q))
      else $error("counter moved without an event edge");

   a_count_stopped: assert property (!ctl_q.run_control && !reload_evt && !we_cl && !we_ch
      |=> $stable(count_q))
      else $error("count moved while stopped");

   a_ext_irq_block: assert property (ext_irq_block && !we_clear
      |=> !$rose(irq_status[IRQ_EXT]))
      else $error("external event raised interrupt in blocked mode");

   // serial hand-off and bus side
   a_baud_tick: assert property (ovf_event && ctl_q.tx_baud_select |=> baud_tick.tx_tick ##1 !baud_tick.tx_tick
      or ovf_event)
      else $error("transmit baud pulse missing");

   a_rx_tick: assert property (ovf_event && ctl_q.rx_baud_select |=> baud_tick.rx_tick)
      else $error("receive baud pulse missing");

   a_tick_quiet: assert property (!ovf_event |=> baud_tick == '0)
      else $error("baud pulse without an overflow");

   a_source_follows: assert property (baud_source == {ctl_q.rx_baud_select, ctl_q.tx_baud_select})
      else $error("baud source disagrees with the selects");

   a_read_control: assert property (rd_take && addr_ok && addr_idx == IDX_CONTROL
      |=> hrdata[7:0] == $past(ctl_q))
      else $error("control read returned wrong value");

   a_rdata_idle: assert property (!(rd_take && addr_ok) |=> hrdata == RDATA_RESET)
      else $error("read data showed outside a read");

endmodule : timer2_core
`default_nettype wire

// file: timer2_pins_model.sv
/*
 * pin-side partner: drives the trigger and event count inputs.
 * assumes hclk from the bench; pins idle high like pulled-up port lines.
 */
`timescale 1ns/100ps
`default_nettype none
module timer2_pins_model
(
   input wire logic hclk,
   output logic event_count_pin,
   output logic external_trigger_pin
);
   initial
   begin
      event_count_pin = 1'b1;
      external_trigger_pin = 1'b1;
   end

   // each level held gap clocks (at least one) so every level gets sampled
   task automatic pulse(input logic trig, input int n, input int gap);
      repeat (n)
      begin
         if (trig)
            external_trigger_pin <= 1'b0;
         else
            event_count_pin <= 1'b0;
         repeat (gap) @(posedge hclk);
         external_trigger_pin <= 1'b1;
         event_count_pin <= 1'b1;
         repeat (gap) @(posedge hclk);
      end
   endtask : pulse
endmodule : timer2_pins_model
`default_nettype wire

// file: timer2_register_and_flags_tb.sv
/*
 * self-checking bench for the second timer: register map, flags, irq, baud hand-off.
 * assumes a zero-wait ahb-lite slave and the pin partner model.
 */
`timescale 1ns/100ps
`default_nettype none
module timer2_register_and_flags_tb;
   import timer2_pkg::*;
   logic hclk, hresetn, hsel, hwrite, irq, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic hready = hreadyout;
   wire logic event_count_pin, external_trigger_pin;
   baud_type baud_tick, baud_source;
   int num_errors = 0;
   int cmp_count = 0;
   int ticks = 0;
   int tick_sel = 0;
   logic [7:0] regs [8] = '{IDX_CONTROL, IDX_RELOAD_LOW, IDX_RELOAD_HIGH, IDX_COUNT_LOW,
      IDX_COUNT_HIGH, IDX_EXTRA, IDX_IRQ_STATUS, IDX_IRQ_MASK};

   timer2_core timer2_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .event_count_pin(event_count_pin),
      .external_trigger_pin(external_trigger_pin), .irq(irq), .baud_tick(baud_tick),
      .baud_source(baud_source));
   timer2_pins_model timer2_pins_model_i (.hclk(hclk), .event_count_pin(event_count_pin),
      .external_trigger_pin(external_trigger_pin));

   initial hclk = 1'b0;
   always #5 hclk = ~hclk;
   always @(posedge hclk)
      if (baud_tick[tick_sel] === 1'b1)
         ticks <= ticks + 1;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      haddr <= {22'h0, idx, 2'b00};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, idx, d, x);
   endtask : wr

   task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, idx, 32'h0, x);
      chk(x, exp);
   endtask : rc

   // overflow lands two edges after the control write and irq registers on that same edge, so let two edges land
   task automatic settle;
      repeat (2) @(posedge hclk);
      #1;
   endtask : settle

   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   initial
   begin
      #200000;
      num_errors++;
      conclude();
   end

   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (regs[i]) rc(regs[i], 32'h0);
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
      wr(8'hc9, 32'hff);
      rc(8'hc9, 32'h0);
      wr(IDX_RELOAD_HIGH, 32'h01);
      wr(IDX_RELOAD_LOW, 32'h5a);
      wr(IDX_COUNT_LOW, 32'hfe);
      wr(IDX_COUNT_HIGH, 32'hff);
      rc(IDX_RELOAD_HIGH, 32'h01);
      rc(IDX_RELOAD_LOW, 32'h5a);
      rc(IDX_COUNT_LOW, 32'hfe);
      rc(IDX_COUNT_HIGH, 32'hff);
      $display("test register map done");
      wr(IDX_CONTROL, 32'h04);
      settle();
      rc(IDX_CONTROL, 32'h84);
      rc(IDX_COUNT_HIGH, 32'h01);
      rc(IDX_IRQ_STATUS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(IDX_IRQ_MASK, 32'h3);
      settle();
      chk({31'h0, irq}, 32'h1);
      wr(IDX_IRQ_STATUS, 32'h1);
      settle();
      chk({31'h0, irq}, 32'h0);
      rc(IDX_CONTROL, 32'h84);
      wr(IDX_CONTROL, 32'h0);
      rc(IDX_CONTROL, 32'h0);
      $display("test overflow done");
      for (int k = 0; k < 2; k++)
      begin
         wr(IDX_COUNT_LOW, 32'hfe);
         wr(IDX_COUNT_HIGH, 32'hff);
         tick_sel = k;
         ticks = 0;
         wr(IDX_CONTROL, k ? 32'h2d : 32'h1d);
         timer2_pins_model_i.pulse(1'b1, 1, 2);
         settle();
         rc(IDX_CONTROL, k ? 32'h2d : 32'h1d);
         rc(IDX_COUNT_HIGH, 32'h01);
         chk({30'h0, baud_source}, k ? 32'h2 : 32'h1);
         chk(ticks, 32'h1);
         wr(IDX_CONTROL, 32'h0);
      end
      $display("test baud hand-off done");
      wr(IDX_CONTROL, 32'h05);
      timer2_pins_model_i.pulse(1'b1, 1, 1);
      settle();
      rc(IDX_CONTROL, 32'h05);
      rc(IDX_RELOAD_HIGH, 32'h01);
      for (int e = 0; e < 3; e++)
      begin
         wr(IDX_EXTRA, e);
         wr(IDX_IRQ_STATUS, 32'h3);
         wr(IDX_COUNT_HIGH, 32'h0);
         wr(IDX_COUNT_LOW, 32'h0);
         wr(IDX_CONTROL, 32'h0d);
         timer2_pins_model_i.pulse(1'b1, 1, 1);
         settle();
         rc(IDX_CONTROL, 32'h4d);
         rc(IDX_IRQ_STATUS, e == 0 ? 32'h2 : 32'h0);
         chk({31'h0, irq}, e == 0 ? 32'h1 : 32'h0);
         rc(IDX_RELOAD_HIGH, 32'h0);
         wr(IDX_CONTROL, 32'h0);
      end
      wr(IDX_EXTRA, 32'h0);
      wr(IDX_RELOAD_HIGH, 32'h12);
      wr(IDX_CONTROL, 32'h0c);
      timer2_pins_model_i.pulse(1'b1, 1, 1);
      settle();
      rc(IDX_COUNT_HIGH, 32'h12);
      rc(IDX_CONTROL, 32'h4c);
      wr(IDX_CONTROL, 32'h0);
      $display("test external trigger done");
      for (int g = 1; g < 4; g += 2)
      begin
         wr(IDX_COUNT_HIGH, 32'h0);
         wr(IDX_COUNT_LOW, 32'h0);
         wr(IDX_CONTROL, 32'h06);
         timer2_pins_model_i.pulse(1'b0, 5, g);
         settle();
         rc(IDX_COUNT_LOW, 32'h5);
         rc(IDX_COUNT_HIGH, 32'h0);
         wr(IDX_CONTROL, 32'h0);
      end
      $display("test event counting done");
      conclude();
   end
endmodule : timer2_register_and_flags_tb
`default_nettype wire
